// File: rtl/bss_boot_select.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
module bss_boot_select (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic rst_pin_in,
   input wire logic reset_polarity_select_in,
   input wire logic program_strobe_pin_in,
   output logic program_strobe_pin_out,
   output logic program_strobe_pin_oe_n_out,
   input wire logic prog_fuse_wr_in,
   input wire logic [7:0] prog_fuse_data_in,
   input wire logic ldr_cmd_valid_in,
   input wire logic [1:0] ldr_cmd_op_in,
   input wire logic [15:0] ldr_cmd_addr_in,
   input wire logic [7:0] ldr_cmd_data_in,
   output logic ldr_cmd_ready_out,
   output logic flash_rd_out,
   output logic flash_wr_out,
   output logic flash_erase_out,
   output logic [15:0] flash_addr_out,
   output logic [7:0] flash_wdata_out,
   output logic core_hold_out,
   output logic [1:0] boot_target_out,
   output logic [15:0] boot_entry_addr_out,
   output logic double_speed_clock_mode_out,
   output logic osc_b_select_out,
   output logic expanded_ram_inhibit_out,
   output logic [2:0] memory_lock_level_out
);

   typedef struct packed {
      logic rst_act;
      logic valid;
      logic hw_cond;
      logic [1:0] target;
      logic [15:0] entry;
      logic [7:0] fuse;
      logic [7:0] status_byte;
      logic [7:0] vector;
      logic waitreq;
      logic [31:0] rdata;
      logic strobe_oe_n;
      logic hold;
      logic dbl;
      logic oscb;
      logic eram_inh;
      logic [2:0] lock;
   } bss_top_state_t;

   bss_top_state_t st_ff;
   bss_top_state_t nxt_st;

   logic [2:0] pins_sync;
   logic rst_pin_sync;
   logic polarity_sync;
   logic strobe_sync;
   logic rst_active;
   logic release_edge;
   logic [7:0] shadow;
   logic bus_req;
   logic bus_accept;
   logic wr_lane0;
   logic ldr_enable;
   logic [1:0] sel_target;
   logic [15:0] sel_entry;

   // pins pass two flops before use, kept aligned in one synchroniser
   bss_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({program_strobe_pin_in, reset_polarity_select_in, rst_pin_in}),
      .sync_out(pins_sync)
   );

   assign rst_pin_sync = pins_sync[0];
   assign polarity_sync = pins_sync[1];
   assign strobe_sync = pins_sync[2];

   // reset pin is active when its level equals the polarity select
   assign rst_active = (rst_pin_sync == polarity_sync);
   assign release_edge = st_ff.rst_act && !rst_active;

   // shadow byte mirrors the fuse store, reserved bit reads zero
   always_comb
   begin
      shadow = st_ff.fuse;
      shadow[bss_pkg::BSS_SHD_RSVD] = 1'b0;
   end

   // boot decision made by logic alone, no code involved
   always_comb
   begin
      sel_target = bss_pkg::BSS_TGT_APP;
      sel_entry = bss_pkg::BSS_APP_ENTRY;
      if (!strobe_sync)
      begin
         sel_target = bss_pkg::BSS_TGT_ROM_LOADER;
         sel_entry = bss_pkg::BSS_ROM_LOADER_ENTRY;
      end
      else if (shadow[bss_pkg::BSS_SHD_JUMP_FUSE])
      begin
         sel_target = bss_pkg::BSS_TGT_APP;
         sel_entry = bss_pkg::BSS_APP_ENTRY;
      end
      else if (st_ff.status_byte == 8'h00)
      begin
         sel_target = bss_pkg::BSS_TGT_APP;
         sel_entry = bss_pkg::BSS_APP_ENTRY;
      end
      else if (st_ff.vector != bss_pkg::BSS_DEFAULT_VECTOR)
      begin
         sel_target = bss_pkg::BSS_TGT_CUSTOM_LOADER;
         sel_entry = {st_ff.vector, bss_pkg::BSS_LOADER_LOW_BYTE};
      end
      else
      begin
         sel_target = bss_pkg::BSS_TGT_ROM_LOADER;
         sel_entry = bss_pkg::BSS_ROM_LOADER_ENTRY;
      end
   end

   assign bus_req = avs_read_in || avs_write_in;
   assign bus_accept = bus_req && !st_ff.waitreq;
   assign wr_lane0 = avs_write_in && bus_accept && avs_byteenable_in[0];

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rst_act = rst_active;

      // core held while reset pin active; released on the decision
      if (rst_active)
      begin
         nxt_st.hold = 1'b1;
         nxt_st.valid = 1'b0;
         nxt_st.strobe_oe_n = 1'b1;
      end
      else if (release_edge)
      begin
         nxt_st.hold = 1'b0;
         nxt_st.valid = 1'b1;
         nxt_st.hw_cond = !strobe_sync;
         nxt_st.target = sel_target;
         nxt_st.entry = sel_entry;
         nxt_st.dbl = !shadow[bss_pkg::BSS_SHD_DOUBLE_SPEED];
         nxt_st.oscb = !shadow[bss_pkg::BSS_SHD_OSC];
         nxt_st.eram_inh = !shadow[bss_pkg::BSS_SHD_ERAM];
         nxt_st.lock = shadow[bss_pkg::BSS_SHD_LOCK_MSB:0];
      end
      else
      begin
         // pin becomes an output after the decision, level ignored
         nxt_st.strobe_oe_n = 1'b0;
      end

      // programmer writes every fuse bit
      if (prog_fuse_wr_in)
      begin
         nxt_st.fuse = prog_fuse_data_in;
      end
      else if (wr_lane0 && (avs_address_in == bss_pkg::BSS_OFS_FUSE_WRITE))
      begin
         // software reaches only the jump fuse
         nxt_st.fuse[bss_pkg::BSS_SHD_JUMP_FUSE] =
            avs_writedata_in[bss_pkg::BSS_SHD_JUMP_FUSE];
      end

      if (wr_lane0 && (avs_address_in == bss_pkg::BSS_OFS_BOOT_STATUS_BYTE))
      begin
         nxt_st.status_byte = avs_writedata_in[7:0];
      end
      if (wr_lane0 && (avs_address_in == bss_pkg::BSS_OFS_SW_BOOT_VECTOR))
      begin
         nxt_st.vector = avs_writedata_in[7:0];
      end

      // two-cycle slave: waitrequest drops for the accepting edge
      if (bus_req && st_ff.waitreq)
      begin
         nxt_st.waitreq = 1'b0;
         nxt_st.rdata = 32'h0000_0000;
         if (avs_read_in)
         begin
            unique case (avs_address_in)
               bss_pkg::BSS_OFS_BOOT_STATUS:
               begin
                  nxt_st.rdata[bss_pkg::BSS_ST_TARGET_LSB +: 2] = st_ff.target;
                  nxt_st.rdata[bss_pkg::BSS_ST_HW_COND] = st_ff.hw_cond;
                  nxt_st.rdata[bss_pkg::BSS_ST_VALID] = st_ff.valid;
                  nxt_st.rdata[bss_pkg::BSS_ST_ENTRY_LSB +: 16] = st_ff.entry;
               end
               bss_pkg::BSS_OFS_HW_SHADOW:
               begin
                  nxt_st.rdata[7:0] = shadow;
               end
               bss_pkg::BSS_OFS_BOOT_STATUS_BYTE:
               begin
                  nxt_st.rdata[7:0] = st_ff.status_byte;
               end
               bss_pkg::BSS_OFS_SW_BOOT_VECTOR:
               begin
                  nxt_st.rdata[7:0] = st_ff.vector;
               end
               bss_pkg::BSS_OFS_API_ENTRY:
               begin
                  nxt_st.rdata[15:0] = bss_pkg::BSS_API_ENTRY;
               end
               default:
               begin
                  nxt_st.rdata = 32'h0000_0000;
               end
            endcase
         end
      end
      else
      begin
         nxt_st.waitreq = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         st_ff.rst_act <= 1'b1;
         st_ff.valid <= 1'b0;
         st_ff.hw_cond <= 1'b0;
         st_ff.target <= bss_pkg::BSS_TGT_APP;
         st_ff.entry <= bss_pkg::BSS_APP_ENTRY;
         st_ff.fuse <= bss_pkg::BSS_RST_FUSE;
         st_ff.status_byte <= bss_pkg::BSS_RST_BOOT_STATUS_BYTE;
         st_ff.vector <= bss_pkg::BSS_RST_SW_BOOT_VECTOR;
         st_ff.waitreq <= 1'b1;
         st_ff.rdata <= 32'h0000_0000;
         st_ff.strobe_oe_n <= 1'b1;
         st_ff.hold <= 1'b1;
         st_ff.dbl <= 1'b0;
         st_ff.oscb <= 1'b0;
         st_ff.eram_inh <= 1'b0;
         st_ff.lock <= 3'h0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // loader frames are served only while a loader was chosen
   assign ldr_enable = st_ff.valid && (st_ff.target != bss_pkg::BSS_TGT_APP);

   bss_flash_xlat #(
      .ADDR_W(16)
   ) u_flash_xlat (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(ldr_enable),
      .cmd_valid_in(ldr_cmd_valid_in),
      .cmd_op_in(ldr_cmd_op_in),
      .cmd_addr_in(ldr_cmd_addr_in),
      .cmd_data_in(ldr_cmd_data_in),
      .cmd_ready_out(ldr_cmd_ready_out),
      .flash_rd_out(flash_rd_out),
      .flash_wr_out(flash_wr_out),
      .flash_erase_out(flash_erase_out),
      .flash_addr_out(flash_addr_out),
      .flash_wdata_out(flash_wdata_out)
   );

   assign avs_readdata_out = st_ff.rdata;
   assign avs_waitrequest_out = st_ff.waitreq;
   assign program_strobe_pin_out = 1'b1;
   assign program_strobe_pin_oe_n_out = st_ff.strobe_oe_n;
   assign core_hold_out = st_ff.hold;
   assign boot_target_out = st_ff.target;
   assign boot_entry_addr_out = st_ff.entry;
   assign double_speed_clock_mode_out = st_ff.dbl;
   assign osc_b_select_out = st_ff.oscb;
   assign expanded_ram_inhibit_out = st_ff.eram_inh;
   assign memory_lock_level_out = st_ff.lock;

endmodule : bss_boot_select

// File: rtl/bss_pkg.sv
package bss_pkg;

   // register byte offsets on the avalon slave
   localparam logic [4:0] BSS_OFS_BOOT_STATUS = 5'h00;
   localparam logic [4:0] BSS_OFS_HW_SHADOW = 5'h04;
   localparam logic [4:0] BSS_OFS_BOOT_STATUS_BYTE = 5'h08;
   localparam logic [4:0] BSS_OFS_SW_BOOT_VECTOR = 5'h0C;
   localparam logic [4:0] BSS_OFS_API_ENTRY = 5'h10;
   localparam logic [4:0] BSS_OFS_FUSE_WRITE = 5'h14;

   // boot status register field positions
   localparam int BSS_ST_TARGET_LSB = 0;
   localparam int BSS_ST_HW_COND = 2;
   localparam int BSS_ST_VALID = 3;
   localparam int BSS_ST_ENTRY_LSB = 16;

   // shadow byte field positions
   localparam int BSS_SHD_DOUBLE_SPEED = 7;
   localparam int BSS_SHD_JUMP_FUSE = 6;
   localparam int BSS_SHD_OSC = 5;
   localparam int BSS_SHD_RSVD = 4;
   localparam int BSS_SHD_ERAM = 3;
   localparam int BSS_SHD_LOCK_MSB = 2;

   // values after reset
   localparam logic [7:0] BSS_RST_FUSE = 8'hA8;
   localparam logic [7:0] BSS_RST_BOOT_STATUS_BYTE = 8'hFF;
   localparam logic [7:0] BSS_RST_SW_BOOT_VECTOR = 8'hFC;

   // fixed addresses
   localparam logic [7:0] BSS_DEFAULT_VECTOR = 8'hFC;
   localparam logic [7:0] BSS_LOADER_LOW_BYTE = 8'h00;
   localparam logic [15:0] BSS_APP_ENTRY = 16'h0000;
   localparam logic [15:0] BSS_ROM_LOADER_ENTRY = 16'hF800;
   localparam logic [15:0] BSS_API_ENTRY = 16'hFFF0;

   typedef enum logic [1:0]
   {
      BSS_TGT_APP = 2'b00,
      BSS_TGT_ROM_LOADER = 2'b01,
      BSS_TGT_CUSTOM_LOADER = 2'b10
   } bss_target_t;

   typedef enum logic [1:0]
   {
      BSS_OP_READ = 2'b00,
      BSS_OP_WRITE = 2'b01,
      BSS_OP_ERASE = 2'b10,
      BSS_OP_NONE = 2'b11
   } bss_flash_op_t;

endpackage : bss_pkg

// File: rtl/bss_sync.sv
module bss_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } bss_sync_state_t;

   bss_sync_state_t st_ff;
   bss_sync_state_t nxt_st;

   if (WIDTH < 1)
   begin : g_chk
      $error("bss_sync width must be at least one");
   end

   always_comb
   begin
      nxt_st.stage1 = async_in;
      nxt_st.stage2 = st_ff.stage1;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stage2;

endmodule : bss_sync

// File: rtl/bss_flash_xlat.sv
module bss_flash_xlat #(
   parameter int ADDR_W = 16
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic enable_in,
   input wire logic cmd_valid_in,
   input wire logic [1:0] cmd_op_in,
   input wire logic [ADDR_W-1:0] cmd_addr_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic flash_rd_out,
   output logic flash_wr_out,
   output logic flash_erase_out,
   output logic [ADDR_W-1:0] flash_addr_out,
   output logic [7:0] flash_wdata_out
);

   typedef struct packed {
      logic ready;
      logic rd;
      logic wr;
      logic er;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } bss_xlat_state_t;

   bss_xlat_state_t st_ff;
   bss_xlat_state_t nxt_st;
   logic take;

   if (ADDR_W < 1)
   begin : g_chk
      $error("bss_flash_xlat address width must be at least one");
   end

   always_comb
   begin
      nxt_st = st_ff;
      take = cmd_valid_in && st_ff.ready;
      nxt_st.rd = 1'b0;
      nxt_st.wr = 1'b0;
      nxt_st.er = 1'b0;
      // loader frames become one flash strobe each, except BSS_OP_NONE frames, which raise none
      if (take)
      begin
         nxt_st.addr = cmd_addr_in;
         nxt_st.wdata = cmd_data_in;
         nxt_st.rd = (cmd_op_in == bss_pkg::BSS_OP_READ);
         nxt_st.wr = (cmd_op_in == bss_pkg::BSS_OP_WRITE);
         nxt_st.er = (cmd_op_in == bss_pkg::BSS_OP_ERASE);
      end
      nxt_st.ready = enable_in && !take;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign cmd_ready_out = st_ff.ready;
   assign flash_rd_out = st_ff.rd;
   assign flash_wr_out = st_ff.wr;
   assign flash_erase_out = st_ff.er;
   assign flash_addr_out = st_ff.addr;
   assign flash_wdata_out = st_ff.wdata;

endmodule : bss_flash_xlat

// File: test/bss_boot_select_properties.sv
module bss_boot_select_chk (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic program_strobe_pin_in,
   input wire logic program_strobe_pin_oe_n_out,
   input wire logic prog_fuse_wr_in,
   input wire logic [7:0] prog_fuse_data_in,
   input wire logic ldr_cmd_valid_in,
   input wire logic [1:0] ldr_cmd_op_in,
   input wire logic ldr_cmd_ready_out,
   input wire logic flash_rd_out,
   input wire logic flash_wr_out,
   input wire logic flash_erase_out,
   input wire logic core_hold_out,
   input wire logic [1:0] boot_target_out,
   input wire logic [15:0] boot_entry_addr_out,
   input wire logic double_speed_clock_mode_out,
   input wire logic osc_b_select_out,
   input wire logic expanded_ram_inhibit_out,
   input wire logic [2:0] memory_lock_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // mirror of the fuse store
   logic [7:0] fuse_ff;
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         fuse_ff <= bss_pkg::BSS_RST_FUSE;
      else if (prog_fuse_wr_in)
         fuse_ff <= prog_fuse_data_in;
      else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
         && avs_address_in == bss_pkg::BSS_OFS_FUSE_WRITE)
         fuse_ff[6] <= avs_writedata_in[6];
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   sequence s_taken;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_decide;
      $fell(core_hold_out);
   endsequence
   a_bus_one_wait: assert property (s_taken |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus wait not one cycle");
   a_pin_forces_loader: assert property (s_decide ##0 !$past(program_strobe_pin_in, 3) |->
      boot_target_out == bss_pkg::BSS_TGT_ROM_LOADER && boot_entry_addr_out == 16'hF800)
      else $error("strobe low did not force loader");
   a_fuse_app: assert property (s_decide ##0 $past(program_strobe_pin_in, 3) && fuse_ff[6] |->
      boot_target_out == bss_pkg::BSS_TGT_APP && boot_entry_addr_out == 16'h0000)
      else $error("jump fuse set did not start application");
   a_option_latch: assert property (s_decide |-> double_speed_clock_mode_out == !fuse_ff[7]
      && osc_b_select_out == !fuse_ff[5] && expanded_ram_inhibit_out == !fuse_ff[3]
      && memory_lock_level_out == fuse_ff[2:0])
      else $error("startup options differ from shadow");
   a_choice_held: assert property (!core_hold_out && !$past(core_hold_out) |->
      $stable(boot_target_out) && $stable(boot_entry_addr_out))
      else $error("boot choice changed after decision");
   a_pin_undriven: assert property (core_hold_out |-> program_strobe_pin_oe_n_out)
      else $error("strobe pin driven during reset");
   a_api_entry: assert property (s_taken ##0 avs_read_in
      && avs_address_in == bss_pkg::BSS_OFS_API_ENTRY |=> avs_readdata_out == 32'h0000_FFF0)
      else $error("call entry wrong");
   a_shadow_read: assert property (s_taken ##0 avs_read_in
      && avs_address_in == bss_pkg::BSS_OFS_HW_SHADOW
      |=> avs_readdata_out == {24'h00_0000, $past(fuse_ff) & 8'hEF})
      else $error("shadow readback wrong");
   a_cmd_strobe: assert property (ldr_cmd_valid_in && ldr_cmd_ready_out |=> !ldr_cmd_ready_out
      && flash_rd_out == ($past(ldr_cmd_op_in) == bss_pkg::BSS_OP_READ)
      && flash_wr_out == ($past(ldr_cmd_op_in) == bss_pkg::BSS_OP_WRITE)
      && flash_erase_out == ($past(ldr_cmd_op_in) == bss_pkg::BSS_OP_ERASE))
      else $error("loader command strobe wrong");
   a_cmd_refused: assert property (boot_target_out == bss_pkg::BSS_TGT_APP && !core_hold_out
      |-> !ldr_cmd_ready_out)
      else $error("loader ready in application");
endmodule : bss_boot_select_chk

bind bss_boot_select bss_boot_select_chk chk_u (.clk_in, .sys_rst_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
   .avs_waitrequest_out, .program_strobe_pin_in, .program_strobe_pin_oe_n_out,
   .prog_fuse_wr_in, .prog_fuse_data_in, .ldr_cmd_valid_in, .ldr_cmd_op_in,
   .ldr_cmd_ready_out, .flash_rd_out, .flash_wr_out, .flash_erase_out, .core_hold_out,
   .boot_target_out, .boot_entry_addr_out, .double_speed_clock_mode_out, .osc_b_select_out,
   .expanded_ram_inhibit_out, .memory_lock_level_out);

// File: test/bss_board_model.sv
module bss_board_model (
   input wire logic clk_in,
   input wire logic por_in,
   input wire logic rst_req_in,
   input wire logic polarity_in,
   input wire logic strobe_low_in,
   input wire logic dev_strobe_in,
   input wire logic dev_strobe_oe_n_in,
   output logic rst_pin_out,
   output logic polarity_out,
   output logic strobe_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] hold_ff;
   logic drive;
   // keep strobe low three edges past reset release, then let go
   always_ff @(posedge clk_in)
   begin
      if (por_in)
         hold_ff <= 2'h0;
      else if (rst_req_in)
         hold_ff <= 2'h3;
      else if (hold_ff != 2'h0)
         hold_ff <= hold_ff - 2'h1;
   end
   assign drive = strobe_low_in && !por_in && (rst_req_in || hold_ff != 2'h0);
   assign rst_pin_out = rst_req_in ? polarity_in : !polarity_in;
   assign polarity_out = polarity_in;
   // pulled up when nobody drives
   assign strobe_out = !dev_strobe_oe_n_in ? dev_strobe_in : !drive;
endmodule : bss_board_model

// File: test/bss_boot_select_tb.sv
module bss_boot_select_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in, sys_rst_in, avs_read_in, avs_write_in, prog_fuse_wr_in, ldr_cmd_valid_in;
   logic [4:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rd;
   logic [3:0] avs_byteenable_in;
   logic avs_waitrequest_out, rst_pin_in, reset_polarity_select_in, program_strobe_pin_in;
   logic program_strobe_pin_out, program_strobe_pin_oe_n_out, ldr_cmd_ready_out, core_hold_out;
   logic [7:0] prog_fuse_data_in, ldr_cmd_data_in, flash_wdata_out;
   logic [1:0] ldr_cmd_op_in, boot_target_out;
   logic [15:0] ldr_cmd_addr_in, flash_addr_out, boot_entry_addr_out;
   logic flash_rd_out, flash_wr_out, flash_erase_out, double_speed_clock_mode_out;
   logic osc_b_select_out, expanded_ram_inhibit_out, rst_req, polarity_req, strobe_low;
   logic [2:0] memory_lock_level_out;
   int miscompares, comparisons, cycles;
   bss_boot_select dut_u (.clk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .rst_pin_in, .reset_polarity_select_in, .program_strobe_pin_in, .program_strobe_pin_out,
      .program_strobe_pin_oe_n_out, .prog_fuse_wr_in, .prog_fuse_data_in, .ldr_cmd_valid_in,
      .ldr_cmd_op_in, .ldr_cmd_addr_in, .ldr_cmd_data_in, .ldr_cmd_ready_out, .flash_rd_out,
      .flash_wr_out, .flash_erase_out, .flash_addr_out, .flash_wdata_out, .core_hold_out,
      .boot_target_out, .boot_entry_addr_out, .double_speed_clock_mode_out, .osc_b_select_out,
      .expanded_ram_inhibit_out, .memory_lock_level_out);
   bss_board_model board_u (.clk_in, .por_in(sys_rst_in), .rst_req_in(rst_req),
      .polarity_in(polarity_req), .strobe_low_in(strobe_low),
      .dev_strobe_in(program_strobe_pin_out), .dev_strobe_oe_n_in(program_strobe_pin_oe_n_out),
      .rst_pin_out(rst_pin_in), .polarity_out(reset_polarity_select_in),
      .strobe_out(program_strobe_pin_in));
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic complete_run;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0)
         @(posedge clk_in);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc
   task automatic opt(input logic [7:0] f);
      chk({double_speed_clock_mode_out, osc_b_select_out, expanded_ram_inhibit_out,
         memory_lock_level_out}, {!f[7], !f[5], !f[3], f[2:0]});
   endtask : opt
   task automatic verify(input logic low, input logic [7:0] f, b, v);
      logic [17:0] e;
      e = low ? 18'h1_F800 : (f[6] || b == 8'h00) ? 18'h0_0000 :
         (v != 8'hFC) ? {2'b10, v, 8'h00} : 18'h1_F800;
      chk({boot_target_out, boot_entry_addr_out}, e);
      rdc(bss_pkg::BSS_OFS_BOOT_STATUS, {e[15:0], 12'h000, 1'b1, low, e[17:16]});
      chk({program_strobe_pin_out, program_strobe_pin_oe_n_out}, 32'h0000_0002);
   endtask : verify
   task automatic boot(input logic polarity, input logic low, input logic [7:0] f, b, v);
      @(posedge clk_in);
      polarity_req <= polarity;
      strobe_low <= low;
      rst_req <= 1'b1;
      repeat (6) @(posedge clk_in);
      rst_req <= 1'b0;
      @(posedge clk_in);
      while (core_hold_out !== 1'b0)
         @(posedge clk_in);
      strobe_low <= 1'b0;
      verify(low, f, b, v);
   endtask : boot
   task automatic ldr(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in);
      ldr_cmd_valid_in <= 1'b1;
      ldr_cmd_op_in <= op;
      ldr_cmd_addr_in <= a;
      ldr_cmd_data_in <= d;
      @(posedge clk_in);
      while (ldr_cmd_ready_out !== 1'b1)
         @(posedge clk_in);
      ldr_cmd_valid_in <= 1'b0;
      @(posedge clk_in);
      chk({flash_rd_out, flash_wr_out, flash_erase_out}, {op == 2'b00, op == 2'b01, op == 2'b10});
      if (op != 2'b11)
         chk(flash_addr_out, a);
      if (op == 2'b01)
         chk(flash_wdata_out, d);
   endtask : ldr
   initial
   begin
      sys_rst_in = 1'b1;
      {avs_read_in, avs_write_in, prog_fuse_wr_in, ldr_cmd_valid_in} = 4'h0;
      avs_address_in = 5'h00;
      avs_writedata_in = 32'h0000_0000;
      avs_byteenable_in = 4'hF;
      prog_fuse_data_in = 8'h00;
      {ldr_cmd_op_in, ldr_cmd_addr_in, ldr_cmd_data_in} = 26'h000_0000;
      {rst_req, polarity_req, strobe_low} = 3'b010;
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      while (core_hold_out !== 1'b0)
         @(posedge clk_in);
      verify(1'b0, 8'hA8, 8'hFF, 8'hFC);
      opt(8'hA8);
      rdc(bss_pkg::BSS_OFS_HW_SHADOW, 32'h0000_00A8);
      rdc(bss_pkg::BSS_OFS_BOOT_STATUS_BYTE, 32'h0000_00FF);
      rdc(bss_pkg::BSS_OFS_SW_BOOT_VECTOR, 32'h0000_00FC);
      rdc(bss_pkg::BSS_OFS_API_ENTRY, 32'h0000_FFF0);
      rdc(5'h18, 32'h0000_0000);
      bus(1'b1, bss_pkg::BSS_OFS_HW_SHADOW, 32'h0000_0000);
      bus(1'b1, bss_pkg::BSS_OFS_FUSE_WRITE, 32'h0000_00FF);
      rdc(bss_pkg::BSS_OFS_HW_SHADOW, 32'h0000_00E8);
      avs_byteenable_in <= 4'hE;
      bus(1'b1, bss_pkg::BSS_OFS_FUSE_WRITE, 32'h0000_0000);
      avs_byteenable_in <= 4'hF;
      rdc(bss_pkg::BSS_OFS_FUSE_WRITE, 32'h0000_0000);
      rdc(bss_pkg::BSS_OFS_HW_SHADOW, 32'h0000_00E8);
      boot(1'b1, 1'b1, 8'hE8, 8'hFF, 8'hFC);
      boot(1'b1, 1'b0, 8'hE8, 8'hFF, 8'hFC);
      chk(ldr_cmd_ready_out, 1'b0);
      bus(1'b1, bss_pkg::BSS_OFS_FUSE_WRITE, 32'h0000_0000);
      bus(1'b1, bss_pkg::BSS_OFS_SW_BOOT_VECTOR, 32'h0000_0012);
      boot(1'b0, 1'b0, 8'hA8, 8'hFF, 8'h12);
      bus(1'b1, bss_pkg::BSS_OFS_BOOT_STATUS_BYTE, 32'h0000_0000);
      boot(1'b0, 1'b0, 8'hA8, 8'h00, 8'h12);
      bus(1'b1, bss_pkg::BSS_OFS_BOOT_STATUS_BYTE, 32'h0000_00FF);
      bus(1'b1, bss_pkg::BSS_OFS_SW_BOOT_VECTOR, 32'h0000_00FC);
      boot(1'b1, 1'b0, 8'hA8, 8'hFF, 8'hFC);
      for (int i = 0; i < 4; i++)
         ldr(i[1:0], 16'hA000 + 16'(i), 8'h3C + 8'(i));
      @(posedge clk_in);
      prog_fuse_wr_in <= 1'b1;
      prog_fuse_data_in <= 8'h57;
      @(posedge clk_in);
      prog_fuse_wr_in <= 1'b0;
      rdc(bss_pkg::BSS_OFS_HW_SHADOW, 32'h0000_0047);
      opt(8'hA8);
      boot(1'b1, 1'b0, 8'h57, 8'hFF, 8'hFC);
      opt(8'h57);
      boot(1'b0, 1'b1, 8'h57, 8'hFF, 8'hFC);
      complete_run();
   end
endmodule : bss_boot_select_tb
